// ---- shared/zac_consts.vh ----
// Constants for the zone access control block.
`ifndef ZAC_CONSTS_VH
`define ZAC_CONSTS_VH

// ----------------------------------------------------------------------------
// Reset values and the locked failure count
// ----------------------------------------------------------------------------
`define ZAC_RULE_RESET     8'hff
`define ZAC_KEYSEL_RESET   8'hff
`define ZAC_FAIL_FULL      8'hff
`define ZAC_FAIL_LOCKED    8'h00
`define ZAC_ID_RESET       56'hffffffffffffff
`define ZAC_CRYPT_RESET    56'hffffffffffffff
`define ZAC_SESS_RESET     64'hffffffffffffffff
`define ZAC_SEED_RESET     64'hffffffffffffffff
`define ZAC_PASS_RESET     24'hffffff

// ----------------------------------------------------------------------------
// Access rule field positions
// ----------------------------------------------------------------------------
`define ZAC_PM_HI          7
`define ZAC_PM_LO          6
`define ZAC_AM_HI          5
`define ZAC_AM_LO          4
`define ZAC_ER_BIT         3
`define ZAC_WLM_BIT        2
`define ZAC_MDF_BIT        1
`define ZAC_PGO_BIT        0

// ----------------------------------------------------------------------------
// Key and passcode selection field positions
// ----------------------------------------------------------------------------
`define ZAC_AK_HI          7
`define ZAC_AK_LO          6
`define ZAC_POK_HI         5
`define ZAC_POK_LO         4
`define ZAC_PW_HI          2
`define ZAC_PW_LO          0

// ----------------------------------------------------------------------------
// Policy encodings
// ----------------------------------------------------------------------------
`define ZAC_PM_NONE        2'h3
`define ZAC_PM_WRITE       2'h2
`define ZAC_AM_NONE        2'h3
`define ZAC_AM_WRITE       2'h2
`define ZAC_AM_NORMAL      2'h1
`define ZAC_AM_DUAL        2'h0

// ----------------------------------------------------------------------------
// Configuration kinds on the internal configuration port
// ----------------------------------------------------------------------------
`define ZAC_KIND_RULE      3'h0
`define ZAC_KIND_KEYSEL    3'h1
`define ZAC_KIND_ID        3'h2
`define ZAC_KIND_CRYPT     3'h3
`define ZAC_KIND_SESS      3'h4
`define ZAC_KIND_SEED      3'h5
`define ZAC_KIND_PASS      3'h6
`define ZAC_KIND_FAIL      3'h7

// ----------------------------------------------------------------------------
// Misc
// ----------------------------------------------------------------------------
`define ZAC_MASTER_SET     3'h7

`endif

// ---- rtl/zac_top.v ----
// Zone access control: policy registers, passcode checks and access decisions.
//
// Operation
// - Passcode policy 11: no passcode needed.
// - Policy 10: reads free, writes need write passcode.
// - Policy 0x: read or write passcode; write grants read.
// - Zone selects one of eight passcode sets.
// - Write passcode verified allows editing that set.
// - Auth policy 11: no authentication needed.
// - Auth policy 10: authentication for writes only.
// - Auth policy 01: full key authentication always.
// - Policy 00: clear key clears, full key full.
// - Clear key select ignored unless policy 00.
// - Policy 00 with clear-only: never set bits.
// - Authenticated zones demand valid checksum on writes.
// - Encryption-required zones refuse cleartext access.
// - Byte-lock pages: lock byte bit guards byte.
// - Byte-lock mode accepts single-byte writes only.
// - Modify-forbidden zone rejects every write.
// - Clear-only zone: writes only clear bits.
// - Zones share seeds; one authentication opens all zones naming that seed.
// - Policy registers act immediately, reset all ones.
// - Successful authentication updates the cryptogram.
// - Authentication or encryption updates the session key.
// - Master passcode writes config until fuse blown.
// - Fail counters step four times, then lock.
// - Eight-trial option shifts counter eight times.
// - Sixteen 8-bit access rule registers.
`include "zac_consts.vh"

module zac_top (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        PERSONALIZATION_FUSE,
  input  wire        EIGHT_TRIAL_OPTION,
  input  wire        ENC_ACTIVE,
  input  wire        CFG_WR,
  input  wire        CFG_RD,
  input  wire [2:0]  CFG_KIND,
  input  wire [3:0]  CFG_IDX,
  input  wire [63:0] CFG_WDATA,
  output reg         CFG_ACK,
  output reg         CFG_OK,
  output reg  [63:0] CFG_RDATA,
  input  wire        PV_REQ,
  input  wire [2:0]  PV_SET,
  input  wire        PV_WRITE,
  input  wire [23:0] PV_VALUE,
  output reg         PV_DONE,
  output reg         PV_PASS,
  input  wire        AUTH_OK,
  input  wire        AUTH_FAIL,
  input  wire [1:0]  AUTH_SEED,
  input  wire [55:0] AUTH_CRYPT_NEXT,
  input  wire [63:0] AUTH_SESS_NEXT,
  input  wire        ENC_OK,
  input  wire [1:0]  ENC_SEED,
  input  wire [63:0] ENC_SESS_NEXT,
  input  wire        ACC_REQ,
  input  wire [3:0]  ACC_ZONE,
  input  wire        ACC_WRITE,
  input  wire        ACC_SINGLE,
  input  wire [2:0]  ACC_BYTE,
  input  wire [7:0]  ACC_LOCK,
  input  wire [7:0]  ACC_OLD,
  input  wire [7:0]  ACC_NEW,
  input  wire        ACC_CKSUM_OK,
  output reg         ACC_DONE,
  output reg         ACC_GRANT,
  output reg  [7:0]  ACC_DATA
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg        rst_meta_reg;
  reg        rst_sync_reg;
  reg [7:0]  rule_reg   [0:15];
  reg [7:0]  keysel_reg [0:15];
  reg [23:0] pass_reg   [0:15];
  reg [7:0]  fail_reg   [0:15];
  reg [55:0] crypt_reg  [0:3];
  reg [63:0] sess_reg   [0:3];
  reg [63:0] seed_reg   [0:3];
  reg [55:0] id_reg;
  reg [7:0]  pw_rd_ok_reg;
  reg [7:0]  pw_wr_ok_reg;
  reg [3:0]  seed_ok_reg;
  integer    i;

  wire rst_n = rst_sync_reg;

  // --------------------------------------------------------------------------
  // Failure counter step
  // --------------------------------------------------------------------------
  // The active-low option bit selects the long sequence.
  function [7:0] fail_step;
    input [7:0] cnt;
    input       eight_n;
    begin
      if (!eight_n) begin
        fail_step = {cnt[6:0], 1'b0};
      end else begin
        fail_step = {cnt[6:4], 1'b0, cnt[2:0], 1'b0};
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Key set index
  // --------------------------------------------------------------------------
  // Only four key sets exist, so the upper index bits are ignored on purpose.
  function [1:0] key_index;
    input [3:0] idx;
    begin
      key_index = idx[1:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Access decision
  // --------------------------------------------------------------------------
  wire [7:0] ar       = rule_reg[ACC_ZONE];
  wire [7:0] kr       = keysel_reg[ACC_ZONE];
  wire [1:0] pm       = ar[`ZAC_PM_HI:`ZAC_PM_LO];
  wire [1:0] am       = ar[`ZAC_AM_HI:`ZAC_AM_LO];
  wire [1:0] ak       = kr[`ZAC_AK_HI:`ZAC_AK_LO];
  wire [1:0] clear_key_select      = kr[`ZAC_POK_HI:`ZAC_POK_LO];
  wire [2:0] pw       = kr[`ZAC_PW_HI:`ZAC_PW_LO];
  wire       pw_rd_ok = pw_rd_ok_reg[pw];
  wire       pw_wr_ok = pw_wr_ok_reg[pw];
  wire       full_ok  = seed_ok_reg[ak];
  wire       clr_ok   = seed_ok_reg[clear_key_select];

  reg        pass_ok;
  reg        auth_ok;
  reg        clear_only;
  reg        write_ok;
  reg        grant;
  reg [7:0]  merged;

  always @* begin
    pass_ok    = 1'b0;
    auth_ok    = 1'b0;
    clear_only = ~ar[`ZAC_PGO_BIT];
    write_ok   = 1'b1;
    // The zone's set index picks the passcode flags used here.
    if (pm == `ZAC_PM_NONE) begin
      pass_ok = 1'b1;
    end else if (pm == `ZAC_PM_WRITE) begin
      pass_ok = ACC_WRITE ? pw_wr_ok : 1'b1;
    end else begin
      pass_ok = ACC_WRITE ? pw_wr_ok : (pw_rd_ok | pw_wr_ok);
    end
    // Seed flags are per seed, so zones naming one seed open together.
    case (am)
      `ZAC_AM_NONE: begin
        auth_ok = 1'b1;
      end
      `ZAC_AM_WRITE: begin
        auth_ok = ACC_WRITE ? full_ok : 1'b1;
      end
      `ZAC_AM_NORMAL: begin
        auth_ok = full_ok;
      end
      default: begin
        auth_ok = full_ok | clr_ok;
        if (!full_ok) begin
          clear_only = 1'b1;
        end
      end
    endcase
    if (ACC_WRITE) begin
      if (am != `ZAC_AM_NONE && !ACC_CKSUM_OK) begin
        write_ok = 1'b0;
      end
      if (!ar[`ZAC_WLM_BIT]) begin
        if (!ACC_SINGLE) begin
          write_ok = 1'b0;
        end
        if (!ACC_LOCK[ACC_BYTE]) begin
          write_ok = 1'b0;
        end
      end
      if (!ar[`ZAC_MDF_BIT]) begin
        write_ok = 1'b0;
      end
    end
    // All requirements must hold together.
    grant = pass_ok & auth_ok & write_ok & (ar[`ZAC_ER_BIT] | ENC_ACTIVE);
    // Merging old and new data keeps stored zeros under the full key only in clear-only zones.
    if (clear_only) begin
      merged = ACC_OLD & ACC_NEW;
    end else begin
      merged = ACC_NEW;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration rights
  // --------------------------------------------------------------------------
  wire       master_ok = pw_wr_ok_reg[`ZAC_MASTER_SET] & PERSONALIZATION_FUSE;
  wire [2:0] cfg_set   = CFG_IDX[3:1];
  reg        cfg_wr_ok;
  reg        cfg_rd_ok;
  reg [63:0] cfg_rd_val;

  always @* begin
    cfg_wr_ok  = master_ok;
    cfg_rd_ok  = 1'b1;
    cfg_rd_val = 64'h0;
    case (CFG_KIND)
      `ZAC_KIND_RULE: begin
        cfg_rd_val = {56'h0, rule_reg[CFG_IDX]};
      end
      `ZAC_KIND_KEYSEL: begin
        cfg_rd_val = {56'h0, keysel_reg[CFG_IDX]};
      end
      `ZAC_KIND_ID: begin
        cfg_rd_val = {8'h0, id_reg};
      end
      `ZAC_KIND_CRYPT: begin
        cfg_rd_val = {8'h0, crypt_reg[key_index(CFG_IDX)]};
      end
      `ZAC_KIND_SESS: begin
        cfg_rd_val = sess_reg[key_index(CFG_IDX)];
      end
      `ZAC_KIND_SEED: begin
        cfg_rd_val = seed_reg[key_index(CFG_IDX)];
      end
      `ZAC_KIND_PASS: begin
        // Passcodes are only visible to the set's write code holder or, while the fuse is intact, the master.
        cfg_wr_ok  = master_ok | pw_wr_ok_reg[cfg_set];
        cfg_rd_ok  = master_ok | pw_wr_ok_reg[cfg_set];
        cfg_rd_val = {40'h0, pass_reg[CFG_IDX]};
      end
      default: begin
        cfg_rd_val = {56'h0, fail_reg[CFG_IDX]};
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Passcode check
  // --------------------------------------------------------------------------
  wire [3:0] pv_idx   = {PV_SET, PV_WRITE};
  wire [7:0] pv_cnt   = fail_reg[pv_idx];
  wire       pv_live  = (pv_cnt != `ZAC_FAIL_LOCKED);
  wire       pv_match = pv_live & (pass_reg[pv_idx] == PV_VALUE);

  // --------------------------------------------------------------------------
  // State update
  // --------------------------------------------------------------------------
  // Hardware events are applied after configuration writes so they win
  // when both touch the same entry in one cycle.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 16; i = i + 1) begin
        rule_reg[i]   <= `ZAC_RULE_RESET;
        keysel_reg[i] <= `ZAC_KEYSEL_RESET;
        pass_reg[i]   <= `ZAC_PASS_RESET;
        fail_reg[i]   <= `ZAC_FAIL_FULL;
      end
      for (i = 0; i < 4; i = i + 1) begin
        crypt_reg[i] <= `ZAC_CRYPT_RESET;
        sess_reg[i]  <= `ZAC_SESS_RESET;
        seed_reg[i]  <= `ZAC_SEED_RESET;
      end
      id_reg       <= `ZAC_ID_RESET;
      pw_rd_ok_reg <= 8'h00;
      pw_wr_ok_reg <= 8'h00;
      seed_ok_reg  <= 4'h0;
      CFG_ACK      <= 1'b0;
      CFG_OK       <= 1'b0;
      CFG_RDATA    <= 64'h0;
      PV_DONE      <= 1'b0;
      PV_PASS      <= 1'b0;
      ACC_DONE     <= 1'b0;
      ACC_GRANT    <= 1'b0;
      ACC_DATA     <= 8'h00;
    end else begin
      // ----------------------------------------------------------------------
      // Answers
      // ----------------------------------------------------------------------
      CFG_ACK  <= CFG_WR | CFG_RD;
      CFG_OK   <= CFG_WR ? cfg_wr_ok : (CFG_RD & cfg_rd_ok);
      PV_DONE  <= PV_REQ;
      PV_PASS  <= PV_REQ & pv_match;
      ACC_DONE <= ACC_REQ;
      ACC_GRANT <= ACC_REQ & grant;
      if (CFG_RD) begin
        CFG_RDATA <= cfg_rd_ok ? cfg_rd_val : 64'h0;
      end
      if (ACC_REQ) begin
        ACC_DATA <= (ACC_WRITE && grant) ? merged : 8'h00;
      end
      // ----------------------------------------------------------------------
      // Configuration writes
      // ----------------------------------------------------------------------
      if (CFG_WR && cfg_wr_ok) begin
        case (CFG_KIND)
          `ZAC_KIND_RULE: begin
            rule_reg[CFG_IDX] <= CFG_WDATA[7:0];
          end
          `ZAC_KIND_KEYSEL: begin
            keysel_reg[CFG_IDX] <= CFG_WDATA[7:0];
          end
          `ZAC_KIND_ID: begin
            id_reg <= CFG_WDATA[55:0];
          end
          `ZAC_KIND_CRYPT: begin
            crypt_reg[key_index(CFG_IDX)] <= CFG_WDATA[55:0];
          end
          `ZAC_KIND_SESS: begin
            sess_reg[key_index(CFG_IDX)] <= CFG_WDATA;
          end
          `ZAC_KIND_SEED: begin
            seed_reg[key_index(CFG_IDX)] <= CFG_WDATA;
          end
          `ZAC_KIND_PASS: begin
            pass_reg[CFG_IDX] <= CFG_WDATA[23:0];
          end
          default: begin
            fail_reg[CFG_IDX] <= CFG_WDATA[7:0];
          end
        endcase
      end
      // ----------------------------------------------------------------------
      // Passcode and cipher events
      // ----------------------------------------------------------------------
      if (PV_REQ) begin
        if (pv_match) begin
          fail_reg[pv_idx] <= `ZAC_FAIL_FULL;
          if (PV_WRITE) begin
            pw_wr_ok_reg[PV_SET] <= 1'b1;
          end else begin
            pw_rd_ok_reg[PV_SET] <= 1'b1;
          end
        end else begin
          // A locked counter stays at zero because the step keeps zeros.
          fail_reg[pv_idx] <= fail_step(pv_cnt, EIGHT_TRIAL_OPTION);
          if (PV_WRITE) begin
            pw_wr_ok_reg[PV_SET] <= 1'b0;
          end else begin
            pw_rd_ok_reg[PV_SET] <= 1'b0;
          end
        end
      end
      if (AUTH_FAIL) begin
        seed_ok_reg[AUTH_SEED] <= 1'b0;
      end
      if (AUTH_OK) begin
        seed_ok_reg[AUTH_SEED] <= 1'b1;
        crypt_reg[AUTH_SEED]   <= AUTH_CRYPT_NEXT;
        sess_reg[AUTH_SEED]    <= AUTH_SESS_NEXT;
      end
      if (ENC_OK) begin
        sess_reg[ENC_SEED] <= ENC_SESS_NEXT;
      end
    end
  end

endmodule

// ---- test/zac_top_props.sv ----
// Port checker for the zone access control block.
module zac_props (
  input wire        CLK,
  input wire        RESET_N,
  input wire        PERSONALIZATION_FUSE,
  input wire        CFG_WR,
  input wire        CFG_RD,
  input wire [2:0]  CFG_KIND,
  input wire        CFG_ACK,
  input wire        CFG_OK,
  input wire [63:0] CFG_RDATA,
  input wire        PV_REQ,
  input wire        PV_DONE,
  input wire        PV_PASS,
  input wire        ACC_REQ,
  input wire        ACC_WRITE,
  input wire [7:0]  ACC_OLD,
  input wire [7:0]  ACC_NEW,
  input wire        ACC_DONE,
  input wire        ACC_GRANT,
  input wire [7:0]  ACC_DATA
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  a_cfg_ack_next: assert property (CFG_WR || CFG_RD |=> CFG_ACK)
    else $error("config answer missing");
  a_cfg_ack_cause: assert property (CFG_ACK |-> $past(CFG_WR) || $past(CFG_RD))
    else $error("config answer without request");
  a_pv_done_next: assert property (PV_REQ |=> PV_DONE)
    else $error("passcode answer missing");
  a_pass_has_cause: assert property (PV_PASS |-> PV_DONE && $past(PV_REQ))
    else $error("passcode pass without request");
  a_acc_done_next: assert property (ACC_REQ |=> ACC_DONE)
    else $error("access answer missing");
  a_refused_no_data: assert property (ACC_DONE && !ACC_GRANT |-> ACC_DATA == 8'h00)
    else $error("refused access carries data");
  a_clear_only_data: assert property (ACC_REQ && ACC_WRITE ##1 ACC_GRANT |->
    ACC_DATA == $past(ACC_NEW) || ACC_DATA == ($past(ACC_OLD) & $past(ACC_NEW)))
    else $error("granted write byte wrong");
  a_fuse_locks_cfg: assert property (CFG_WR && CFG_KIND != 3'h6 &&
    !PERSONALIZATION_FUSE |=> !CFG_OK)
    else $error("config write after fuse");
  a_refused_read_zero: assert property (CFG_RD ##1 !CFG_OK |-> CFG_RDATA == 64'h0)
    else $error("refused read returned data");
  a_acc_data_holds: assert property (!ACC_REQ |=> $stable(ACC_DATA))
    else $error("access data moved without request");
endmodule

bind zac_top zac_props u_props (.CLK, .RESET_N, .PERSONALIZATION_FUSE, .CFG_WR, .CFG_RD,
  .CFG_KIND, .CFG_ACK, .CFG_OK, .CFG_RDATA, .PV_REQ, .PV_DONE, .PV_PASS, .ACC_REQ,
  .ACC_WRITE, .ACC_OLD, .ACC_NEW, .ACC_DONE, .ACC_GRANT, .ACC_DATA);

// ---- test/zac_cipher_model.sv ----
// Cipher-side model: authentication and encryption result pulses.
module zac_cipher_model #(
  parameter [55:0] CV = 56'h13579bdf02468a,
  parameter [63:0] SV = 64'h0f1e2d3c4b5a6978
) (
  input  wire         CLK,
  output logic        AUTH_OK,
  output logic        AUTH_FAIL,
  output logic [1:0]  AUTH_SEED,
  output logic [55:0] AUTH_CRYPT_NEXT,
  output logic [63:0] AUTH_SESS_NEXT,
  output logic        ENC_OK,
  output logic [1:0]  ENC_SEED,
  output logic [63:0] ENC_SESS_NEXT
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {AUTH_OK, AUTH_FAIL, ENC_OK, AUTH_SEED, ENC_SEED} = 0;
    {AUTH_CRYPT_NEXT, AUTH_SESS_NEXT, ENC_SESS_NEXT} = 0;
  end
  // One-cycle result; values are inverted afterwards so stale data never matches.
  task pulse(input logic ok, input logic en, input logic [1:0] s);
    @(negedge CLK);
    AUTH_OK = ok;
    AUTH_FAIL = !ok && !en;
    ENC_OK = en;
    AUTH_SEED = s;
    ENC_SEED = s;
    AUTH_CRYPT_NEXT = CV;
    AUTH_SESS_NEXT = SV;
    ENC_SESS_NEXT = SV;
    @(negedge CLK);
    AUTH_OK = 0;
    AUTH_FAIL = 0;
    ENC_OK = 0;
    AUTH_SEED = ~s;
    ENC_SEED = ~s;
    AUTH_CRYPT_NEXT = ~CV;
    AUTH_SESS_NEXT = ~SV;
    ENC_SESS_NEXT = ~SV;
  endtask
endmodule

// ---- test/zac_top_bench.sv ----
// Self-checking bench for the zone access control block.
`include "zac_consts.vh"
module zac_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst_n = 0, fuse = 1, eto = 1, enc = 0;
  logic        cwr = 0, crd = 0, pvr = 0, pvw = 0, ar = 0, aw = 0, as = 0, ck = 0;
  logic [2:0]  ckind = 0, pvs = 0, ab = 0;
  logic [3:0]  cidx = 0, az = 0;
  logic [63:0] cwd = 0;
  logic [23:0] pvv = 0;
  logic [7:0]  al = 0, ao = 0, an = 0;
  wire         cack, cok, pvd, pvp, aok, afl, eok, ad, ag;
  wire  [63:0] crdata, asn, esn;
  wire  [55:0] acn;
  wire  [1:0]  asd, esd;
  wire  [7:0]  adat;
  int          err_count = 0, comparisons = 0, i;
  logic [7:0]  rl [7] = '{8'hbf, 8'h3f, 8'hef, 8'hce, 8'hfd, 8'hf7, 8'hfb};
  logic [7:0]  ks [7] = '{8'hf8, 8'hf9, 8'h3f, 8'h6f, 8'hff, 8'hff, 8'hff};
  logic [7:0]  fc [4] = '{8'hee, 8'hcc, 8'h88, 8'h00};
  localparam [55:0] CV = 56'h13579bdf02468a;
  localparam [63:0] SV = 64'h0f1e2d3c4b5a6978;

  always #12.5 clk = ~clk;

  zac_cipher_model #(.CV(CV), .SV(SV)) cm (.CLK(clk), .AUTH_OK(aok), .AUTH_FAIL(afl),
    .AUTH_SEED(asd), .AUTH_CRYPT_NEXT(acn), .AUTH_SESS_NEXT(asn), .ENC_OK(eok),
    .ENC_SEED(esd), .ENC_SESS_NEXT(esn));

  zac_top dut (.CLK(clk), .RESET_N(rst_n), .PERSONALIZATION_FUSE(fuse),
    .EIGHT_TRIAL_OPTION(eto), .ENC_ACTIVE(enc), .CFG_WR(cwr), .CFG_RD(crd), .CFG_KIND(ckind),
    .CFG_IDX(cidx), .CFG_WDATA(cwd), .CFG_ACK(cack), .CFG_OK(cok), .CFG_RDATA(crdata),
    .PV_REQ(pvr), .PV_SET(pvs), .PV_WRITE(pvw), .PV_VALUE(pvv), .PV_DONE(pvd), .PV_PASS(pvp),
    .AUTH_OK(aok), .AUTH_FAIL(afl), .AUTH_SEED(asd), .AUTH_CRYPT_NEXT(acn),
    .AUTH_SESS_NEXT(asn), .ENC_OK(eok), .ENC_SEED(esd), .ENC_SESS_NEXT(esn), .ACC_REQ(ar),
    .ACC_ZONE(az), .ACC_WRITE(aw), .ACC_SINGLE(as), .ACC_BYTE(ab), .ACC_LOCK(al),
    .ACC_OLD(ao), .ACC_NEW(an), .ACC_CKSUM_OK(ck), .ACC_DONE(ad), .ACC_GRANT(ag),
    .ACC_DATA(adat));

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Every wait is bounded; a missing answer ends the run.
  task wt(input logic f);
    if (f !== 1'b1) begin
      err_count++;
      test_done;
    end
  endtask

  task cfg(input logic w, input logic [2:0] k, input logic [3:0] x, input logic [63:0] d);
    int n;
    cwr = w;
    crd = !w;
    ckind = k;
    cidx = x;
    cwd = d;
    @(negedge clk);
    cwr = 0;
    crd = 0;
    cwd = ~d;
    for (n = 0; n < 4 && cack !== 1'b1; n++) @(negedge clk);
    wt(cack);
  endtask

  task pv(input logic [2:0] s, input logic w, input logic [23:0] v);
    int n;
    pvr = 1;
    pvs = s;
    pvw = w;
    pvv = v;
    @(negedge clk);
    pvr = 0;
    pvv = ~v;
    for (n = 0; n < 4 && pvd !== 1'b1; n++) @(negedge clk);
    wt(pvd);
  endtask

  task acc(input logic [3:0] z, input logic w, input logic s, input logic [2:0] b,
           input logic [7:0] l, input logic [7:0] o, input logic [7:0] v, input logic k);
    int n;
    {ar, az, aw, as, ab, al, ao, an, ck} = {1'b1, z, w, s, b, l, o, v, k};
    @(negedge clk);
    ar = 0;
    an = ~v;
    for (n = 0; n < 4 && ad !== 1'b1; n++) @(negedge clk);
    wt(ad);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    cfg(0, `ZAC_KIND_RULE, 4'h5, 0);
    chk(crdata, `ZAC_RULE_RESET);
    cfg(0, `ZAC_KIND_FAIL, 4'h4, 0);
    chk(crdata, `ZAC_FAIL_FULL);
    cfg(1, `ZAC_KIND_RULE, 4'h0, 0);
    chk(cok, 0);
    pv(`ZAC_MASTER_SET, 1, `ZAC_PASS_RESET);
    chk(pvp, 1);
    for (i = 0; i < 7; i++) begin
      cfg(1, `ZAC_KIND_RULE, 4'(i + 2), 64'(rl[i]));
      chk(cok, 1);
      cfg(1, `ZAC_KIND_KEYSEL, 4'(i + 2), 64'(ks[i]));
    end
    acc(4'h1, 1, 1, 0, 8'hff, 8'hff, 8'h5a, 0);
    chk(adat, 8'h5a);
    acc(4'h2, 0, 0, 0, 8'hff, 8'hff, 8'h00, 0);
    chk(ag, 1);
    acc(4'h2, 1, 1, 0, 8'hff, 8'hff, 8'h11, 0);
    chk(ag, 0);
    pv(3'h0, 1, `ZAC_PASS_RESET);
    acc(4'h2, 1, 1, 0, 8'hff, 8'hff, 8'h11, 0);
    chk(ag, 1);
    acc(4'h3, 0, 0, 0, 8'hff, 8'hff, 8'h00, 0);
    chk(ag, 0);
    pv(3'h1, 1, `ZAC_PASS_RESET);
    acc(4'h3, 0, 0, 0, 8'hff, 8'hff, 8'h00, 0);
    chk(ag, 1);
    acc(4'h4, 0, 0, 0, 8'hff, 8'hff, 8'h00, 1);
    chk(ag, 1);
    acc(4'h4, 1, 1, 0, 8'hff, 8'hff, 8'h22, 1);
    chk(ag, 0);
    cm.pulse(1, 0, 2'h0);
    acc(4'h4, 1, 1, 0, 8'hff, 8'hff, 8'h22, 0);
    chk(ag, 0);
    acc(4'h4, 1, 1, 0, 8'hff, 8'hff, 8'h22, 1);
    chk(adat, 8'h22);
    cfg(0, `ZAC_KIND_CRYPT, 4'h0, 0);
    chk(crdata, 64'(CV));
    cfg(0, `ZAC_KIND_SESS, 4'h0, 0);
    chk(crdata, SV);
    acc(4'h5, 1, 1, 0, 8'hff, 8'hf0, 8'h3c, 1);
    chk(ag, 0);
    cm.pulse(1, 0, 2'h2);
    acc(4'h5, 1, 1, 0, 8'hff, 8'hf0, 8'h3c, 1);
    chk(adat, 8'h30);
    cm.pulse(1, 0, 2'h1);
    acc(4'h5, 1, 1, 0, 8'hff, 8'h0f, 8'hf0, 1);
    chk(adat, 8'h00);
    cm.pulse(0, 1, 2'h3);
    cfg(0, `ZAC_KIND_SESS, 4'h3, 0);
    chk(crdata, SV);
    acc(4'h6, 1, 1, 0, 8'hff, 8'hff, 8'h01, 0);
    chk(ag, 0);
    acc(4'h7, 0, 0, 0, 8'hff, 8'hff, 8'h00, 0);
    chk(ag, 0);
    enc = 1;
    acc(4'h7, 0, 0, 0, 8'hff, 8'hff, 8'h00, 0);
    chk(ag, 1);
    acc(4'h8, 1, 1, 3'h3, 8'hf7, 8'hff, 8'h44, 0);
    chk(ag, 0);
    acc(4'h8, 1, 1, 3'h3, 8'h08, 8'hff, 8'h44, 0);
    chk(ag, 1);
    acc(4'h8, 1, 0, 3'h3, 8'hff, 8'hff, 8'h44, 0);
    chk(ag, 0);
    for (i = 0; i < 4; i++) begin
      pv(3'h2, 0, 24'h0);
      cfg(0, `ZAC_KIND_FAIL, 4'h4, 0);
      chk(crdata, 64'(fc[i]));
    end
    pv(3'h2, 0, `ZAC_PASS_RESET);
    chk(pvp, 0);
    eto = 0;
    pv(3'h3, 0, 24'h0);
    cfg(0, `ZAC_KIND_FAIL, 4'h6, 0);
    chk(crdata, 64'h0fe);
    pv(3'h3, 0, `ZAC_PASS_RESET);
    cfg(0, `ZAC_KIND_FAIL, 4'h6, 0);
    chk(crdata, `ZAC_FAIL_FULL);
    cm.pulse(0, 0, 2'h0);
    acc(4'h4, 1, 1, 0, 8'hff, 8'hff, 8'h22, 1);
    chk(ag, 0);
    fuse = 0;
    cfg(1, `ZAC_KIND_RULE, 4'h1, 0);
    chk(cok, 0);
    test_done;
  end
endmodule
